// file: bmsc_consts.svh
// constants for the buck mode sequence control block
`ifndef BMSC_CONSTS_SVH
`define BMSC_CONSTS_SVH

// ------------------------------------------------------------
// clocks and timing
// ------------------------------------------------------------
`define BMSC_CLK_KHZ 50000
`define BMSC_OSC_KHZ 1000
`define BMSC_OSC_DIV (`BMSC_CLK_KHZ / `BMSC_OSC_KHZ)
`define BMSC_SYNC_LOSS_PER 4
`define BMSC_SKIP_TICKS 32
`define BMSC_SS_DWELL 64
`define BMSC_PG_DLY_US 250
`define BMSC_LBO_DLY_US 500
`define BMSC_PG_DLY_CYC ((`BMSC_PG_DLY_US * `BMSC_CLK_KHZ + 999) / 1000)
`define BMSC_LBO_DLY_CYC ((`BMSC_LBO_DLY_US * `BMSC_CLK_KHZ + 999) / 1000)

// ------------------------------------------------------------
// switch current limits in mA
// ------------------------------------------------------------
`define BMSC_LIM0_MA 300
`define BMSC_LIM1_MA 600
`define BMSC_LIM2_MA 1200
`define BMSC_LIMF_MA 2400

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define BMSC_OFF_CTRL 8'h00
`define BMSC_OFF_DWELL 8'h04
`define BMSC_OFF_STAT 8'h08
`define BMSC_CTRL_EN_BIT 0
`define BMSC_CTRL_PWM_BIT 1
`define BMSC_CTRL_RST 2'h1

`endif

// file: bmsc_pkg.sv
// types shared by the buck mode sequence control block
package bmsc_pkg;

  typedef enum logic [1:0] {st_off, st_soft, st_run} bmsc_state_e;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } bmsc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bmsc_apb_rsp_s;

  // comparator and pin levels, all asynchronous to pclk
  typedef struct packed {
    logic enable;
    logic sync;
    logic supply_lockout;
    logic out_low;
    logic out_good;
    logic low_supply_sense_in;
    logic load_low;
    logic thermal;
    logic dropout;
    logic trip;
  } bmsc_pins_s;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic ref_on;
    logic osc_on;
    logic pwm_mode;
    logic full_duty;
  } bmsc_drv_s;

endpackage

// file: bmsc_ctrl.sv
// buck converter mode, soft-start and status flag sequencing with apb registers
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bmsc_consts.svh"
//
// Behaviour
// [RULE1] soft-start limit steps 300, 600, 1200 mA
// [RULE2] full 2400 mA limit after soft-start
// [RULE3] skip mode exits when output-low reported
// [RULE4] dropout holds high-side switch on
// [RULE5] enable low shuts everything off
// [RULE6] thermal condition keeps reference on
// [RULE7] enable rise starts through soft-start
// [RULE8] lockout blocks switch and rectifier
// [RULE9] internal 1 MHz oscillator without sync clock
// [RULE10] external 0.8 to 1.4 MHz clock accepted
// [RULE11] first sync edge locks immediately
// [RULE12] four periods without edge revert internal
// [RULE13] locked to sync forbids pulse skipping
// [RULE14] sync low allows light-load skipping
// [RULE15] output-good driven low while disabled
// [RULE16] output-good held low for 250 us
// [RULE17] output-good low after and during shutdown
// [RULE18] output-good released when output good
// [RULE19] warning low while sense below trip
// [RULE20] warning undefined 500 us after enable
// [RULE21] disabled leaves warning output high impedance
// [RULE22] unused sense input tied to ground
// [RULE23] static sync high forces fixed frequency
// [RULE24] skip entry after 32 low-load cycles
// [RULE25] step dwell configurable by parameter, register
// [RULE26] comparator inputs synchronised before use
module bmsc_ctrl
  import bmsc_pkg::*;
#(
  parameter int PG_DLY_CYC = `BMSC_PG_DLY_CYC,
  parameter int LBO_DLY_CYC = `BMSC_LBO_DLY_CYC,
  parameter int SS_DWELL = `BMSC_SS_DWELL,
  parameter int SKIP_TICKS = `BMSC_SKIP_TICKS,
  parameter int OSC_DIV = `BMSC_OSC_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire bmsc_apb_req_s apb_req,
  output var bmsc_apb_rsp_s apb_rsp,
  input wire bmsc_pins_s pins,
  output var bmsc_drv_s drv,
  output var logic [11:0] ilim_ma,
  output var logic output_good_flag_o,
  output var logic output_good_flag_oe_n,
  output var logic low_supply_warn_out_o,
  output var logic low_supply_warn_out_oe_n
);

  // ------------------------------------------------------------
  // parameter checks and widths
  // ------------------------------------------------------------
  if (PG_DLY_CYC < 1 || LBO_DLY_CYC < 1 || SS_DWELL < 1 || SS_DWELL > 65535 ||
      SKIP_TICKS < 1 || OSC_DIV < 2) begin : g_bad_param
    $error("bmsc_ctrl: parameter out of range");
  end

  localparam int LOSS = `BMSC_SYNC_LOSS_PER * OSC_DIV;
  localparam int PGW = $clog2(PG_DLY_CYC + 1);
  localparam int LBW = $clog2(LBO_DLY_CYC + 1);
  localparam int SKW = $clog2(SKIP_TICKS + 1);
  localparam int OSW = $clog2(OSC_DIV);
  localparam int LSW = $clog2(LOSS);
  localparam int NPIN = $bits(bmsc_pins_s);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] pin_q;
  bmsc_pins_s ps;

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pins[i]; // RULE26
        pin_q[i] <= meta_q[i];
      end
    end
  end

  assign ps = bmsc_pins_s'(pin_q);

  // ------------------------------------------------------------
  // registers and their decode
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [15:0] dwell_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] stat_w;
  logic [31:0] rd_w;

  wire sel_ctrl = apb_req.paddr == `BMSC_OFF_CTRL;
  wire sel_dwell = apb_req.paddr == `BMSC_OFF_DWELL;
  wire sel_stat = apb_req.paddr == `BMSC_OFF_STAT;
  wire hit = sel_ctrl | sel_dwell | sel_stat;
  wire setup = apb_req.psel & ~apb_req.penable;
  wire access = apb_req.psel & apb_req.penable & pready_q;
  wire bad = ~hit | (apb_req.pwrite & sel_stat);
  wire wr_ctrl = access & apb_req.pwrite & sel_ctrl;
  wire wr_dwell = access & apb_req.pwrite & sel_dwell;

  assign rd_w = sel_ctrl ? {30'h0000_0000, ctrl_q} :
                sel_dwell ? {16'h0000, dwell_q} :
                sel_stat ? stat_w : 32'h0000_0000;

  // zero wait states: pready rises for the access phase of every transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & bad;
      prdata_q <= (setup & ~apb_req.pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BMSC_CTRL_RST;
      dwell_q <= 16'(SS_DWELL);
    end else begin
      if (wr_ctrl) ctrl_q <= apb_req.pwdata[1:0];
      if (wr_dwell) dwell_q <= apb_req.pwdata[15:0]; // RULE25
    end
  end

  assign apb_rsp = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

  // ------------------------------------------------------------
  // enable, lockout and oscillator
  // ------------------------------------------------------------
  logic [OSW-1:0] osc_cnt_q;
  logic sync_d1_q;
  logic locked_q;
  logic [LSW-1:0] loss_cnt_q;

  wire en = ps.enable & ctrl_q[`BMSC_CTRL_EN_BIT];
  wire go = en & ~ps.supply_lockout;
  wire osc_wrap = en & (osc_cnt_q == OSW'(OSC_DIV - 1));
  wire sync_rise = ps.sync & ~sync_d1_q;
  wire loss_end = locked_q & ~sync_rise & (loss_cnt_q == LSW'(LOSS - 1));
  // a sync edge also ticks when still unlocked, so the very first edge counts
  wire tick = locked_q ? sync_rise : (osc_wrap | sync_rise);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_q <= '0;
    end else if (!en) begin
      osc_cnt_q <= '0; // RULE5
    end else begin
      osc_cnt_q <= osc_wrap ? '0 : osc_cnt_q + 1'b1; // RULE9
    end
  end

  // no frequency qualification: any edge rate inside the range is used as is
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d1_q <= 1'b0;
      locked_q <= 1'b0;
      loss_cnt_q <= '0;
    end else begin
      sync_d1_q <= ps.sync;
      if (sync_rise) begin
        locked_q <= 1'b1; // RULE11 RULE10
        loss_cnt_q <= '0;
      end else if (loss_end) begin
        locked_q <= 1'b0; // RULE12
        loss_cnt_q <= '0;
      end else if (locked_q) begin
        loss_cnt_q <= loss_cnt_q + 1'b1;
      end
    end
  end

  sync_lock_a: assert property (sync_rise |=> locked_q) // RULE11
    else $error("sync edge did not lock");
  sync_loss_a: assert property (loss_end |=> !locked_q ##1 !locked_q || $past(sync_rise)) // RULE12
    else $error("sync loss did not revert");

  // ------------------------------------------------------------
  // soft-start sequencing
  // ------------------------------------------------------------
  bmsc_state_e st_q;
  bmsc_state_e st_d;
  logic [1:0] step_q;
  logic [1:0] step_d;
  logic [15:0] dw_cnt_q;
  logic [11:0] ilim_q;
  logic [11:0] ilim_d;

  wire dw_done = ({1'b0, dw_cnt_q} + 17'h0_0001) >= {1'b0, dwell_q};
  wire adv = (st_q == st_soft) & tick & dw_done;

  always_comb begin
    st_d = st_q;
    step_d = step_q;
    case (st_q)
      st_off: begin
        step_d = 2'h0;
        if (go) st_d = st_soft; // RULE7
      end
      st_soft: begin
        if (!go) begin
          st_d = st_off;
        end else if (adv && step_q == 2'h2) begin
          st_d = st_run;
        end else if (adv) begin
          step_d = step_q + 2'h1; // RULE1
        end
      end
      st_run: begin
        if (!go) st_d = st_off;
      end
      default: st_d = st_off;
    endcase
  end

  assign ilim_d = (st_d == st_run) ? 12'(`BMSC_LIMF_MA) : // RULE2
                  (st_d != st_soft) ? 12'h000 :
                  (step_d == 2'h0) ? 12'(`BMSC_LIM0_MA) :
                  (step_d == 2'h1) ? 12'(`BMSC_LIM1_MA) : 12'(`BMSC_LIM2_MA); // RULE1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= st_off;
      step_q <= 2'h0;
      dw_cnt_q <= 16'h0000;
      ilim_q <= 12'h000;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      ilim_q <= ilim_d;
      dw_cnt_q <= (adv || st_q != st_soft) ? 16'h0000 : dw_cnt_q + (tick ? 16'h0001 : 16'h0000);
    end
  end

  ss_start_a: assert property (st_q == st_off && go |=> st_q == st_soft && ilim_q == 12'(`BMSC_LIM0_MA)) // RULE7
    else $error("start did not enter soft-start at lowest limit");
  ss_steps_a: assert property (st_q == st_soft && step_q == 2'h1 |-> ilim_q == 12'(`BMSC_LIM1_MA)) // RULE1
    else $error("middle soft-start step limit wrong");
  full_limit_a: assert property (st_q == st_run |-> ilim_q == 12'(`BMSC_LIMF_MA)) // RULE2
    else $error("full limit missing after soft-start");

  // ------------------------------------------------------------
  // pulse skipping
  // ------------------------------------------------------------
  logic skip_q;
  logic skip_d;
  logic [SKW-1:0] low_cnt_q;

  // static high or locked sync, or the register, keeps fixed frequency
  wire skip_ok = ~ps.sync & ~locked_q & ~ctrl_q[`BMSC_CTRL_PWM_BIT] & (st_q == st_run); // RULE13 RULE14 RULE23
  wire skip_go = tick & ps.load_low & (low_cnt_q >= SKW'(SKIP_TICKS - 1)); // RULE24

  // output low also blocks entry, else a saturated count re-enters at once
  assign skip_d = (~skip_ok | ps.out_low) ? 1'b0 : // RULE3
                  (skip_q | skip_go);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
      low_cnt_q <= '0;
    end else begin
      skip_q <= skip_d;
      if (!ps.load_low) begin
        low_cnt_q <= '0;
      end else if (tick && low_cnt_q != SKW'(SKIP_TICKS)) begin
        low_cnt_q <= low_cnt_q + 1'b1; // RULE24
      end
    end
  end

  skip_exit_a: assert property (skip_q && ps.out_low |=> !skip_q) // RULE3
    else $error("skip mode kept with output low");
  skip_lock_a: assert property (locked_q || ps.sync |=> !skip_q) // RULE13
    else $error("skip mode while sync present");
  skip_entry_a: assert property ($rose(skip_q) |-> $past(low_cnt_q) >= SKW'(SKIP_TICKS - 1)) // RULE24
    else $error("skip entered too early");

  // ------------------------------------------------------------
  // power stage drive
  // ------------------------------------------------------------
  bmsc_drv_s drv_q;
  bmsc_drv_s drv_d;
  logic hs_d;

  wire act = go & (st_q != st_off); // RULE8 RULE5

  // in skip mode the stage idles unless dropout holds the switch on; pulses resume once skip is left
  assign hs_d = ~act ? 1'b0 :
                ps.dropout ? 1'b1 : // RULE4
                skip_q ? 1'b0 :
                tick ? 1'b1 :
                ps.trip ? 1'b0 : drv_q.hs_on;

  assign drv_d = '{hs_on: hs_d,
                   ls_on: act & ~hs_d & ~skip_d, // RULE8
                   ref_on: en | ps.thermal, // RULE6
                   osc_on: en, // RULE5
                   pwm_mode: ~skip_d,
                   full_duty: act & ps.dropout}; // RULE4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_q <= '0;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign drv = drv_q;
  assign ilim_ma = ilim_q;

  off_drive_a: assert property (!en |=> !drv_q.hs_on && !drv_q.ls_on && !drv_q.osc_on) // RULE5
    else $error("stage active while disabled");
  lockout_gate_a: assert property (ps.supply_lockout |=> !drv_q.hs_on && !drv_q.ls_on) // RULE8
    else $error("stage active under lockout");
  full_duty_a: assert property (act && ps.dropout |=> drv_q.hs_on && drv_q.full_duty) // RULE4
    else $error("dropout did not hold switch on");
  ref_thermal_a: assert property (ps.thermal |=> drv_q.ref_on) // RULE6
    else $error("reference off during thermal condition");

  // ------------------------------------------------------------
  // output-good and low-supply warning flags
  // ------------------------------------------------------------
  logic [PGW-1:0] pg_cnt_q;
  logic [LBW-1:0] lb_cnt_q;
  logic pg_oe_n_q;
  logic lb_oe_n_q;
  logic od_lo_q;

  wire pg_valid = pg_cnt_q == PGW'(PG_DLY_CYC);
  wire lb_valid = lb_cnt_q == LBW'(LBO_DLY_CYC);

  // shutdown clears the timer, so the low hold restarts on every enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_cnt_q <= '0;
      lb_cnt_q <= '0;
      pg_oe_n_q <= 1'b0;
      lb_oe_n_q <= 1'b1;
      od_lo_q <= 1'b0;
    end else begin
      od_lo_q <= 1'b0;
      pg_cnt_q <= !go ? '0 : pg_valid ? pg_cnt_q : pg_cnt_q + 1'b1; // RULE16 RULE17
      lb_cnt_q <= !en ? '0 : lb_valid ? lb_cnt_q : lb_cnt_q + 1'b1; // RULE20
      pg_oe_n_q <= en & pg_valid & ps.out_good; // RULE15 RULE18
      lb_oe_n_q <= ~(en & lb_valid & ps.low_supply_sense_in); // RULE19 RULE21
    end
  end

  assign output_good_flag_o = od_lo_q;
  assign output_good_flag_oe_n = pg_oe_n_q;
  assign low_supply_warn_out_o = od_lo_q;
  assign low_supply_warn_out_oe_n = lb_oe_n_q;

  pg_off_a: assert property (!en |=> !pg_oe_n_q) // RULE15
    else $error("output-good not pulled low while disabled");
  pg_hold_a: assert property (!pg_valid |=> !pg_oe_n_q) // RULE16
    else $error("output-good released before delay");
  lb_hiz_a: assert property (!en |=> lb_oe_n_q) // RULE21
    else $error("warning driven while disabled");
  lb_warn_a: assert property (en && lb_valid && ps.low_supply_sense_in |=> !lb_oe_n_q) // RULE19
    else $error("warning not driven for low sense");
  lb_hold_a: assert property (!lb_valid |=> lb_oe_n_q) // RULE20
    else $error("warning driven inside its start window");

  // ------------------------------------------------------------
  // status word
  // ------------------------------------------------------------
  assign stat_w = {19'h0_0000, ps.thermal, step_q, 2'(st_q), drv_q.hs_on, ~lb_oe_n_q,
                   pg_oe_n_q, pg_valid, skip_q, locked_q, ps.supply_lockout, en};

endmodule // bmsc_ctrl

`default_nettype wire

// file: bmsc_host_model.sv
// host side model driving the enable pin and the sync pin
`timescale 1ns/1ps
`default_nettype none
module bmsc_host_model (
  input wire logic en_cmd,
  input wire logic clk_run,
  input wire logic sync_lvl,
  output logic enable,
  output logic sync
);
  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  assign enable = en_cmd;
  // sync clock of 160 ns runs only while commanded, else static level
  initial begin
    sync = 1'b0;
    forever begin
      if (clk_run) begin
        #80 sync = ~sync;
      end else begin
        sync = sync_lvl;
        @(clk_run or sync_lvl);
        // keeps later sync edges away from the pclk edges
        #5;
      end
    end
  end
endmodule // bmsc_host_model
`default_nettype wire

// file: test_buck_mode_sequence_control.sv
// self-checking bench for the buck mode sequence control block
`timescale 1ns/1ps
`default_nettype none
module test_buck_mode_sequence_control;
  import bmsc_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic pclk, presetn, en_cmd, clk_run, sync_lvl, h_en, h_sync;
  logic lockout, out_low, out_good, sense, load_low, thermal, dropout, trip;
  bmsc_apb_req_s req;
  bmsc_apb_rsp_s rsp;
  bmsc_pins_s pins;
  bmsc_drv_s drv;
  logic [11:0] ilim;
  logic pg_o, pg_oe_n, lbo_o, lbo_oe_n, e;
  logic [31:0] rd;
  int n_mismatch, n_checks;
  assign pins = {h_en, h_sync, lockout, out_low, out_good, sense, load_low, thermal, dropout, trip};
  bmsc_host_model u_host (.en_cmd(en_cmd), .clk_run(clk_run), .sync_lvl(sync_lvl), .enable(h_en), .sync(h_sync));
  // short counts keep the run brief
  bmsc_ctrl #(.PG_DLY_CYC(20), .LBO_DLY_CYC(30), .SS_DWELL(2), .SKIP_TICKS(32), .OSC_DIV(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .pins(pins), .drv(drv), .ilim_ma(ilim),
    .output_good_flag_o(pg_o), .output_good_flag_oe_n(pg_oe_n),
    .low_supply_warn_out_o(lbo_o), .low_supply_warn_out_oe_n(lbo_oe_n));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // wait states tolerated: pready polled for up to 20 cycles after the access edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(rsp.pready), 32'h1, "bus answer missing");
    rd = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_ilim(input logic [11:0] exp);
    int n;
    n = 0;
    while (ilim !== exp && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(ilim), 32'(exp), "current limit step");
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h1, "ctrl reset value");
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h2, "dwell reset value");
    apb(8'h04, 1'b1, 32'h3);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h3, "dwell readback");
    apb(8'h0C, 1'b0, 32'h0);
    chk(32'(e), 32'h1, "unmapped read not refused");
    apb(8'h08, 1'b1, 32'hFFFF);
    chk(32'(e), 32'h1, "status write not refused");
  endtask
  task t_start;
    out_good <= 1'b1;
    sense <= 1'b1;
    en_cmd <= 1'b1;
    wait_ilim(12'h12C);
    cyc(5);
    chk(32'(pg_oe_n), 32'h0, "flag released early");
    wait_ilim(12'h258);
    wait_ilim(12'h4B0);
    wait_ilim(12'h960);
    cyc(10);
    chk(32'(pg_oe_n), 32'h1, "flag not released");
    chk(32'(lbo_oe_n), 32'h0, "warning not driven");
    sense <= 1'b0;
    out_good <= 1'b0;
    cyc(5);
    chk(32'(lbo_oe_n), 32'h1, "warning stuck");
    chk(32'(pg_oe_n), 32'h0, "flag stuck high");
  endtask
  task t_sync;
    clk_run <= 1'b1;
    cyc(10);
    apb(8'h08, 1'b0, 32'h0);
    chk(32'(rd[2]), 32'h1, "sync not locked");
    chk(32'(drv.pwm_mode), 32'h1, "skip while locked");
    clk_run <= 1'b0;
    cyc(50);
    apb(8'h08, 1'b0, 32'h0);
    chk(32'(rd[2]), 32'h0, "lock not lost");
  endtask
  task t_skip;
    int n;
    n = 0;
    sync_lvl <= 1'b1;
    load_low <= 1'b1;
    cyc(300);
    chk(32'(drv.pwm_mode), 32'h1, "skip with sync high");
    load_low <= 1'b0;
    sync_lvl <= 1'b0;
    cyc(5);
    load_low <= 1'b1;
    cyc(150);
    chk(32'(drv.pwm_mode), 32'h1, "skip entered early");
    while (drv.pwm_mode !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(drv.pwm_mode), 32'h0, "skip never entered");
    out_low <= 1'b1;
    cyc(5);
    chk(32'(drv.pwm_mode), 32'h1, "skip not left");
    out_low <= 1'b0;
    load_low <= 1'b0;
  endtask
  task t_drop_lock;
    dropout <= 1'b1;
    cyc(5);
    chk(32'(drv.full_duty), 32'h1, "no full duty");
    cyc(20);
    chk(32'(drv.hs_on), 32'h1, "switch not held on");
    dropout <= 1'b0;
    lockout <= 1'b1;
    cyc(25);
    chk(32'({drv.hs_on, drv.ls_on}), 32'h0, "stage on in lockout");
    lockout <= 1'b0;
    wait_ilim(12'h12C);
  endtask
  task t_off;
    thermal <= 1'b1;
    en_cmd <= 1'b0;
    cyc(5);
    chk(32'({drv.hs_on, drv.ls_on, drv.osc_on}), 32'h0, "stage on while off");
    chk(32'(drv.ref_on), 32'h1, "reference off in thermal");
    chk(32'(pg_oe_n), 32'h0, "flag not pulled low");
    chk(32'(lbo_oe_n), 32'h1, "warning not released");
    thermal <= 1'b0;
    cyc(5);
    chk(32'(drv.ref_on), 32'h0, "reference still on");
    out_good <= 1'b1;
    sense <= 1'b1;
    en_cmd <= 1'b1;
    wait_ilim(12'h12C);
    chk(32'(pg_oe_n), 32'h0, "flag high after restart");
    chk(32'(lbo_oe_n), 32'h1, "warning driven in its window");
  endtask
  // ------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    req = '0;
    {en_cmd, clk_run, sync_lvl, lockout, out_low, out_good} = '0;
    {sense, load_low, thermal, dropout, trip} = '0;
    n_mismatch = 0;
    n_checks = 0;
    cyc(10);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(ilim), 32'h0, "limit not zero at rest");
    chk(32'(lbo_oe_n), 32'h1, "warning driven at rest");
    chk(32'({pg_o, lbo_o}), 32'h0, "open-drain data not low");
    t_regs;
    t_start;
    t_sync;
    t_skip;
    t_drop_lock;
    t_off;
    tally_and_finish;
  end
  // whole sequence needs under 1000 cycles
  initial begin
    cyc(20000);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule // test_buck_mode_sequence_control
`default_nettype wire
